// ===== src/ics_defs.svh
`ifndef ICS_DEFS_SVH
`define ICS_DEFS_SVH

// register byte offsets on the apb side
`define ICS_OFF_CTRL 12'h000
`define ICS_OFF_MASKEN 12'h004
`define ICS_OFF_EVSTAT 12'h008
`define ICS_OFF_EVMASK 12'h00C

// control/status field positions
`define ICS_BIT_IRQ 15
`define ICS_LVL_HI 14
`define ICS_LVL_LO 13
`define ICS_VEC_HI 12
`define ICS_VEC_LO 6
`define ICS_BIT_DIS 5
`define ICS_ONES_HI 4
`define ICS_ONES_LO 2

// level encodings presented to the core
`define ICS_LVL_ANY 2'h0
`define ICS_LVL_P0 2'h1
`define ICS_LVL_P1 2'h2
`define ICS_LVL_P23 2'h3

// event status bits
`define ICS_EV_ENTRY 0
`define ICS_EV_OVERWRITE 1
`define ICS_EV_W 2

// reset values
`define ICS_RST_DIS 1'h0
`define ICS_RST_MASKEN 1'h0
`define ICS_RST_EVMASK 2'h0
`define ICS_RST_VECTOR 21'h000000

// clock edges the reset vector is held after release
`define ICS_RST_HOLD_EDGES 2'h2

`endif

// ===== src/ics_pkg.sv
package ics_pkg;

    // request offered by the pending/priority logic upstream
    typedef struct packed {
        logic valid;
        logic [1:0] prio;
        logic swlp;
        logic fixed;
        logic fast;
        logic [6:0] vector;
        logic [20:0] addr;
    } ics_req_t;

    // what is presented to the core
    typedef struct packed {
        logic irq;
        logic [1:0] level;
        logic [20:0] vector_number_field;
        logic rst_vec;
    } ics_core_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ics_apb_req_t;

endpackage

// ===== src/ics_top.sv
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ics_defs.svh"
// Function
// - read-only bits 14:13 mirror the nesting level presented to the core.
// - level code 00 none or lowest soft, 01 p0, 10 p1, 11 p2/p3.
// - level and vector fields update only when the core enters a routine.
// - read-only bits 12:6 hold the vector number of the last taken request.
// - for a fast request the vector field holds low jump address bits.
// - writable bit 5 set blocks all core requests, fixed and maskable, but not o_irq; zero by default.
// - bits 4:2 always read as ones, writes ignored.
// - bits 1:0 always read as zeros, writes ignored.
// - while reset is asserted the reset vector drives the vector outputs.
// - reset vector stays presented through the second edge after release.
// - reset defaults everything; maskables off, fixed core requests stay enabled.
// - read-only bit 15 is one while a request is driven to the core.
module ics_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire ics_pkg::ics_apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire ics_pkg::ics_req_t i_req,
    input wire logic i_core_ack,
    output ics_pkg::ics_core_t o_core,
    output logic o_irq
);

    logic dis_ff;
    logic masken_ff;
    logic [1:0] lvl_field_ff;
    logic [6:0] vec_field_ff;
    logic [`ICS_EV_W-1:0] evstat_ff;
    logic [`ICS_EV_W-1:0] evmask_ff;
    logic [1:0] hold_cnt_ff;
    logic hold_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic irq_ff;
    ics_pkg::ics_core_t core_ff;

    logic apb_access;
    logic apb_done;
    logic wr_done;
    logic mapped;
    logic req_allowed;
    logic entry;
    logic [1:0] nxt_level;
    logic [6:0] nxt_vec_field;
    logic [15:0] ctrl_rd;
    logic [31:0] nxt_prdata;
    logic [`ICS_EV_W-1:0] ev_set;
    logic [`ICS_EV_W-1:0] ev_clr;
    logic sel_ctrl;
    logic sel_masken;
    logic sel_evstat;
    logic sel_evmask;
    logic byte0_wr;
    logic nxt_dis;
    logic nxt_masken;
    logic [`ICS_EV_W-1:0] nxt_evmask;
    logic [`ICS_EV_W-1:0] nxt_evstat;
    logic nxt_irq;
    logic nxt_pready;
    logic nxt_pslverr;
    logic [31:0] rd_word;
    logic [1:0] nxt_lvl_field;
    logic [6:0] nxt_vec_capture;
    logic nxt_hold;
    logic [1:0] nxt_hold_cnt;
    ics_pkg::ics_core_t nxt_core;

    assign apb_access = i_apb.psel & i_apb.penable;
    assign apb_done = apb_access & pready_ff;
    assign wr_done = apb_done & i_apb.pwrite;
    assign sel_ctrl = (i_apb.paddr == `ICS_OFF_CTRL);
    assign sel_masken = (i_apb.paddr == `ICS_OFF_MASKEN);
    assign sel_evstat = (i_apb.paddr == `ICS_OFF_EVSTAT);
    assign sel_evmask = (i_apb.paddr == `ICS_OFF_EVMASK);
    // only the low byte holds writable bits, so only its strobe matters
    assign byte0_wr = wr_done & i_apb.pstrb[0];
    assign mapped = sel_ctrl | sel_masken | sel_evstat | sel_evmask;

    // fixed core requests bypass the maskable enable, the global disable blocks all
    assign req_allowed = i_req.valid & ~dis_ff & (i_req.fixed | masken_ff) & ~hold_ff;

    always_comb begin
        if (i_req.swlp) begin
            nxt_level = `ICS_LVL_ANY;
        end else begin
            case (i_req.prio)
                2'h0: nxt_level = `ICS_LVL_P0;
                2'h1: nxt_level = `ICS_LVL_P1;
                default: nxt_level = `ICS_LVL_P23;
            endcase
        end
    end

    // core entry only counts while a request is actually being offered
    assign entry = i_core_ack & core_ff.irq & ~hold_ff;
    assign nxt_vec_field = i_req.fast ? i_req.addr[6:0] : i_req.vector;

    // reset vector hold after release
    always_comb begin
        nxt_hold = hold_ff;
        nxt_hold_cnt = hold_cnt_ff;
        if (hold_ff) begin
            nxt_hold_cnt = hold_cnt_ff + 2'h1;
            if (hold_cnt_ff + 2'h1 == `ICS_RST_HOLD_EDGES) begin
                nxt_hold = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_ff <= 1'b1;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_cnt_ff <= 2'h0;
        end else begin
            hold_cnt_ff <= nxt_hold_cnt;
        end
    end

    // outputs toward the core; the core must see the reset vector on both edges
    always_comb begin
        nxt_core.irq = req_allowed;
        nxt_core.level = req_allowed ? nxt_level : `ICS_LVL_ANY;
        nxt_core.vector_number_field = req_allowed ? i_req.addr : 21'h000000;
        nxt_core.rst_vec = 1'b0;
        if (hold_ff && (hold_cnt_ff + 2'h1 != `ICS_RST_HOLD_EDGES)) begin
            nxt_core.irq = 1'b0;
            nxt_core.level = `ICS_LVL_ANY;
            nxt_core.vector_number_field = `ICS_RST_VECTOR;
            nxt_core.rst_vec = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            core_ff.irq <= 1'b0;
            core_ff.level <= `ICS_LVL_ANY;
            core_ff.vector_number_field <= `ICS_RST_VECTOR;
            core_ff.rst_vec <= 1'b1;
        end else begin
            core_ff <= nxt_core;
        end
    end

    // captured fields; a nested entry may overwrite before software reads
    always_comb begin
        nxt_lvl_field = lvl_field_ff;
        nxt_vec_capture = vec_field_ff;
        if (entry) begin
            nxt_lvl_field = core_ff.level;
            nxt_vec_capture = nxt_vec_field;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lvl_field_ff <= `ICS_LVL_ANY;
        end else begin
            lvl_field_ff <= nxt_lvl_field;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            vec_field_ff <= 7'h00;
        end else begin
            vec_field_ff <= nxt_vec_capture;
        end
    end

    // software controls, one next value per register
    always_comb begin
        nxt_dis = dis_ff;
        if (byte0_wr && sel_ctrl) begin
            nxt_dis = i_apb.pwdata[`ICS_BIT_DIS];
        end
    end

    always_comb begin
        nxt_masken = masken_ff;
        if (byte0_wr && sel_masken) begin
            nxt_masken = i_apb.pwdata[0];
        end
    end

    always_comb begin
        nxt_evmask = evmask_ff;
        if (byte0_wr && sel_evmask) begin
            nxt_evmask = i_apb.pwdata[`ICS_EV_W-1:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dis_ff <= `ICS_RST_DIS;
        end else begin
            dis_ff <= nxt_dis;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            masken_ff <= `ICS_RST_MASKEN;
        end else begin
            masken_ff <= nxt_masken;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            evmask_ff <= `ICS_RST_EVMASK;
        end else begin
            evmask_ff <= nxt_evmask;
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    assign ev_set[`ICS_EV_ENTRY] = entry;
    assign ev_set[`ICS_EV_OVERWRITE] = entry & evstat_ff[`ICS_EV_ENTRY];
    assign ev_clr = (byte0_wr && sel_evstat) ? i_apb.pwdata[`ICS_EV_W-1:0] : {`ICS_EV_W{1'b0}};

    always_comb begin
        nxt_evstat = (evstat_ff & ~ev_clr) | ev_set;
    end

    // irq follows the new status in the same edge, not one later
    always_comb begin
        nxt_irq = |(nxt_evstat & evmask_ff);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            evstat_ff <= {`ICS_EV_W{1'b0}};
        end else begin
            evstat_ff <= nxt_evstat;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // control/status read image
    always_comb begin
        ctrl_rd = 16'h0000;
        ctrl_rd[`ICS_BIT_IRQ] = core_ff.irq;
        ctrl_rd[`ICS_LVL_HI:`ICS_LVL_LO] = lvl_field_ff;
        ctrl_rd[`ICS_VEC_HI:`ICS_VEC_LO] = vec_field_ff;
        ctrl_rd[`ICS_BIT_DIS] = dis_ff;
        ctrl_rd[`ICS_ONES_HI:`ICS_ONES_LO] = 3'h7;
        ctrl_rd[1:0] = 2'h0;
    end

    always_comb begin
        case (i_apb.paddr)
            `ICS_OFF_CTRL: rd_word = {16'h0000, ctrl_rd};
            `ICS_OFF_MASKEN: rd_word = {31'h00000000, masken_ff};
            `ICS_OFF_EVSTAT: rd_word = {30'h00000000, evstat_ff};
            `ICS_OFF_EVMASK: rd_word = {30'h00000000, evmask_ff};
            default: rd_word = 32'h00000000;
        endcase
    end

    // one wait state: registered answer costs a cycle but keeps outputs glitch free
    always_comb begin
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h00000000;
        if (apb_access && !pready_ff) begin
            nxt_pready = 1'b1;
            nxt_pslverr = ~mapped;
            if (!i_apb.pwrite) begin
                nxt_prdata = rd_word;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= nxt_pready;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prdata_ff <= 32'h00000000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_core = core_ff;
    assign o_irq = irq_ff;

endmodule
`default_nettype wire

// ===== tb/ics_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ics_core_model #(
    parameter int DLY = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_en,
    input wire ics_pkg::ics_core_t i_core,
    output logic o_ack
);
    int cnt;
    // jumps only after the request stood DLY cycles; one pulse per jump
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 0;
            o_ack <= 1'b0;
        end else begin
            cnt <= (i_core.irq && !o_ack) ? cnt + 1 : 0;
            o_ack <= i_en && i_core.irq && !o_ack && cnt >= DLY;
        end
    end
endmodule
`default_nettype wire

// ===== tb/ics_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module ics_top_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire ics_pkg::ics_apb_req_t i_apb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire ics_pkg::ics_req_t i_req,
    input wire logic i_core_ack,
    input wire ics_pkg::ics_core_t o_core,
    input wire logic o_irq
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    wire logic rd_ctl = o_pready && !i_apb.pwrite && i_apb.paddr == 12'h000;
    sequence s_hold;
        o_core.rst_vec ##1 o_core.rst_vec ##1 !o_core.rst_vec;
    endsequence
    a_rst_hold: assert property ($fell(i_rst) |-> s_hold)
        else $error("reset vector hold wrong");
    a_rst_vab: assert property (o_core.rst_vec |-> o_core.vector_number_field == 21'h0 && !o_core.irq)
        else $error("reset vector not driven");
    a_fixed_bits: assert property (rd_ctl |-> o_prdata[4:0] == 5'h1C && o_prdata[31:16] == 16'h0)
        else $error("fixed bits wrong");
    a_ready_wait: assert property (i_apb.psel && i_apb.penable && !o_pready |=> o_pready)
        else $error("pready late");
    a_ready_pulse: assert property (o_pready |-> i_apb.psel && i_apb.penable ##1 !o_pready)
        else $error("pready not a pulse");
    a_unmapped_err: assert property (o_pready && (i_apb.paddr > 12'h00C || i_apb.paddr[1:0] != 2'h0)
        |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    a_level_code: assert property (o_core.irq |-> o_core.level == ($past(i_req.swlp) ? 2'h0 :
        $past(i_req.prio) == 2'h0 ? 2'h1 : $past(i_req.prio) == 2'h1 ? 2'h2 : 2'h3))
        else $error("level code wrong");
    a_req_cause: assert property (o_core.irq |-> $past(i_req.valid) && o_core.vector_number_field == $past(i_req.addr))
        else $error("request without cause");
endmodule
bind ics_top ics_top_props props_u (.i_clk(i_clk), .i_rst(i_rst), .i_apb(i_apb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_req(i_req), .i_core_ack(i_core_ack), .o_core(o_core),
    .o_irq(o_irq));
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, s) begin \
    tests_run++; \
    if ((s) !== (x)) begin fails++; $display("BAD %s exp %h got %h", n, x, s); end \
end
module tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic en = 1'b0;
    logic ack, pready, pslverr, irq, e;
    logic [31:0] prdata, q;
    logic [1:0] lv, pl = 2'h0;
    logic [6:0] nv, pv = 7'h0;
    int fails = 0;
    int tests_run = 0;
    ics_pkg::ics_apb_req_t apb = '0;
    ics_pkg::ics_req_t req = '0;
    ics_pkg::ics_core_t core;
    always #50 i_clk = ~i_clk;
    ics_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_req(req), .i_core_ack(ack), .o_core(core), .o_irq(irq));
    ics_core_model #(.DLY(2)) core_u (.i_clk(i_clk), .i_rst(i_rst), .i_en(en), .i_core(core), .o_ack(ack));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic bound(input int n);
        if (n == 20) begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        apb <= '{1'b1, 1'b0, w, a, d, 4'hF};
        @(posedge i_clk);
        apb.penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge i_clk);
        bound(n);
        q = prdata;
        e = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask
    task automatic take();
        int n;
        en <= 1'b1;
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge i_clk);
        en <= 1'b0;
        bound(n);
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        `CHK("vector in reset", {1'b1, 21'h0}, {core.rst_vec, core.vector_number_field})
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        `CHK("vector held", 1'b1, core.rst_vec)
        @(posedge i_clk);
        `CHK("vector freed", 1'b0, core.rst_vec)
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 12'(4 * i), 32'h0);
            `CHK("reset value", i == 0 ? 32'h1C : 32'h0, q)
        end
        xfer(1'b1, 12'h010, 32'hFFFFFFFF);
        `CHK("unmapped", 1'b1, e)
        $display("reset test done");
        xfer(1'b1, 12'h000, 32'hFFFFFFFF);
        xfer(1'b0, 12'h000, 32'h0);
        `CHK("ctrl write", 32'h3C, q)
        req <= '{1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 7'h0, 21'h0};
        repeat (3) @(posedge i_clk);
        `CHK("disabled", 1'b0, core.irq)
        xfer(1'b1, 12'h000, 32'h0);
        repeat (2) @(posedge i_clk);
        `CHK("fixed enabled", 1'b1, core.irq)
        req.fixed <= 1'b0;
        repeat (3) @(posedge i_clk);
        `CHK("maskable off", 1'b0, core.irq)
        xfer(1'b1, 12'h004, 32'h1);
        xfer(1'b1, 12'h00C, 32'h1);
        $display("disable test done");
        // swlp rides on prio 3 to show it overrides; last case is a fast request
        for (int k = 0; k < 6; k++) begin
            req <= '{1'b1, 2'(k == 0 ? 3 : k == 5 ? 2 : k - 1), k == 0, 1'b0, k == 5, 7'(65 + k), 21'h1F000 + 21'(k)};
            lv = k == 0 ? 2'h0 : k >= 3 ? 2'h3 : 2'(k);
            nv = k == 5 ? 7'(k) : 7'(65 + k);
            repeat (2) @(posedge i_clk);
            `CHK("core level", lv, core.level)
            xfer(1'b0, 12'h000, 32'h0);
            `CHK("before entry", {1'b1, pl, pv}, q[15:6])
            take();
            xfer(1'b0, 12'h000, 32'h0);
            `CHK("after entry", {1'b1, lv, nv}, q[15:6])
            pl = lv;
            pv = nv;
        end
        $display("level test done");
        `CHK("irq raised", 1'b1, irq)
        xfer(1'b1, 12'h00C, 32'h0);
        repeat (2) @(posedge i_clk);
        `CHK("irq masked", 1'b0, irq)
        xfer(1'b0, 12'h008, 32'h0);
        `CHK("events", 32'h3, q)
        xfer(1'b1, 12'h008, 32'h3);
        xfer(1'b1, 12'h00C, 32'h1);
        xfer(1'b0, 12'h008, 32'h0);
        `CHK("cleared", {1'b0, 32'h0}, {irq, q})
        $display("event test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
